// ===== rtl/gpx_port.sv
// general-purpose 8-pin port with external interrupt and alternate functions
// assumes avalon-mm master on the cpu side, pins synchronous to clock
//
// The Avalon-MM register port and the register addresses were decided locally.
`default_nettype none
`include "gpx_cfg.svh"
module gpx_port #(
   parameter int WIDTH = 8,
   parameter logic [7:0] IRQ_PINS = 8'hFF // pins that have interrupt capability
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // cpu interrupt handshake
   input wire logic cpu_irq_masked,
   input wire logic vector_fetch,
   input wire logic cpu_wait_mode,
   input wire logic cpu_halt_mode,
   output logic ext_irq_req,
   output logic wake_req,
   // peripheral side
   input wire gpx_pkg::gpx_af_type af,
   output logic [7:0] af_in,
   // pads
   input wire logic [7:0] pin_in,
   output gpx_pkg::gpx_pad_type pad
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   initial begin
      if (WIDTH < 1 || WIDTH > 8) $error("gpx_port supports one to eight pins");
   end
   // ----------------------------------------------------------------
   // reset synchroniser
   // ----------------------------------------------------------------
   logic rst_meta_ff; // first stage, read only by second
   logic rst_sync_ff; // released reset used everywhere
   // two-stage release, assert stays asynchronous
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // port programming, all cleared by the released reset
   // no byte lane other than zero carries port bits
   logic [7:0] pin_data_latch_ff; // data latch
   logic [7:0] dir_ff; // one = output
   logic [7:0] opt_ff; // option bits
   logic [1:0] ext_irq_sensitivity_ctrl_ff; // sensitivity code
   logic pend_ff; // hidden request latch
   gpx_pkg::gpx_bus_state_type bus_state_ff;
   // combinational results feeding the registers
   logic [31:0] nxt_readdata;
   logic [1:0] nxt_response;
   logic [7:0] read_val;
   logic [7:0] nxt_out;
   logic [7:0] nxt_oe_n;
   logic [7:0] nxt_pull;
   logic [7:0] nxt_af_in;
   logic [7:0] event_hit;
   logic [7:0] irq_enable;
   // bus decode strobes, only while the slave is idle
   logic acc;
   logic wr_data;
   logic wr_dir;
   logic wr_opt;
   logic wr_sens;
   // byte lane zero holds all port bits
   function automatic logic is_write(input logic [7:0] ofs);
      is_write = avs_write && avs_byteenable[0] && (avs_address == ofs) && (bus_state_ff == gpx_pkg::gpx_bus_idle);
   endfunction
   assign acc = (avs_read || avs_write) && (bus_state_ff == gpx_pkg::gpx_bus_idle);
   assign wr_data = is_write(`GPX_OFS_DATA);
   assign wr_dir = is_write(`GPX_OFS_DIR);
   assign wr_opt = is_write(`GPX_OFS_OPT);
   assign wr_sens = is_write(`GPX_OFS_SENS);
   // data latch, written in any mode
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         pin_data_latch_ff <= `GPX_RST_PORT;
      end else if (wr_data) begin
         pin_data_latch_ff <= avs_writedata[7:0];
      end
   end
   // direction and option bits
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         dir_ff <= `GPX_RST_PORT; // floating inputs after reset
         opt_ff <= `GPX_RST_PORT;
      end else begin
         if (wr_dir) dir_ff <= avs_writedata[7:0];
         if (wr_opt) opt_ff <= avs_writedata[7:0];
      end
   end
   // sensitivity code
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         ext_irq_sensitivity_ctrl_ff <= `GPX_RST_SENS;
      end else if (wr_sens) begin
         ext_irq_sensitivity_ctrl_ff <= avs_writedata[1:0];
      end
   end
   // ----------------------------------------------------------------
   // pin logic
   // ----------------------------------------------------------------
   gpx_pad_mux #(.WIDTH(8)) u_mux (
      .latch(pin_data_latch_ff),
      .dir(dir_ff),
      .opt(opt_ff),
      .af_out_en(af.af_out_en),
      .af_out(af.af_out),
      .af_od(af.af_od),
      .af_in_en(af.af_in_en),
      .pin_level(pin_in),
      .nxt_out(nxt_out),
      .nxt_oe_n(nxt_oe_n),
      .nxt_pull(nxt_pull),
      .nxt_af_in(nxt_af_in),
      .read_val(read_val)
   );
   // pad drive registered; low-power modes do not touch it
   // one cycle of delay keeps every top output on a flip-flop
   // pins without pull-up hardware would mask nxt_pull here
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         pad.out <= 8'h00;
         pad.oe_n <= 8'hFF;
         pad.pull_up <= 8'h00;
         af_in <= 8'h00;
      end else begin
         pad.out <= nxt_out;
         pad.oe_n <= nxt_oe_n;
         pad.pull_up <= nxt_pull;
         af_in <= nxt_af_in;
      end
   end
   // ----------------------------------------------------------------
   // external interrupt
   // ----------------------------------------------------------------
   // interrupt input = dir 0, opt 1, capable pin
   assign irq_enable = ~dir_ff & opt_ff & IRQ_PINS;
   gpx_edge_qual #(.WIDTH(8)) u_qual (
      .clock(clock),
      .rst_sync_n(rst_sync_ff),
      .pin_level(pin_in),
      .irq_enable(irq_enable),
      .sens(ext_irq_sensitivity_ctrl_ff),
      .event_hit(event_hit)
   );
   // hidden request latch; event wins over fetch clear
   // no bus path reads or writes it directly
   // a clear that meets an event loses, so no event is lost
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         pend_ff <= 1'b0;
      end else if (|event_hit) begin
         pend_ff <= 1'b1;
      end else if (vector_fetch || wr_sens) begin
         pend_ff <= 1'b0;
      end
   end
   // request to cpu only while unmasked; wake in wait or halt
   // masking hides the request but keeps the latch set
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         ext_irq_req <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         ext_irq_req <= pend_ff & ~cpu_irq_masked;
         wake_req <= pend_ff & ~cpu_irq_masked & (cpu_wait_mode | cpu_halt_mode);
      end
   end
   // ----------------------------------------------------------------
   // bus slave: one wait cycle, then answer
   // ----------------------------------------------------------------
   always_comb begin
      nxt_response = 2'h0;
      unique case (avs_address)
         `GPX_OFS_DATA: nxt_readdata = {24'h00_0000, read_val};
         `GPX_OFS_DIR: nxt_readdata = {24'h00_0000, dir_ff};
         `GPX_OFS_OPT: nxt_readdata = {24'h00_0000, opt_ff};
         `GPX_OFS_SENS: nxt_readdata = {30'h0000_0000, ext_irq_sensitivity_ctrl_ff};
         `GPX_OFS_AF_EN: nxt_readdata = {24'h00_0000, af.af_out_en};
         `GPX_OFS_STATUS: nxt_readdata = {30'h0000_0000, wake_req, ext_irq_req};
         default: begin
            nxt_readdata = 32'h0000_0000;
            nxt_response = 2'h2; // slave error
         end
      endcase
   end
   // waitrequest high at idle, low for one cycle after taking access
   // a write lands at the take edge; the master still holds
   // read data and response stand until the next access
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         bus_state_ff <= gpx_pkg::gpx_bus_idle;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         avs_response <= 2'h0;
      end else begin
         unique case (bus_state_ff)
            gpx_pkg::gpx_bus_idle: begin
               if (acc) begin
                  bus_state_ff <= gpx_pkg::gpx_bus_resp;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= avs_read ? nxt_readdata : 32'h0000_0000;
                  avs_response <= nxt_response;
               end
            end
            gpx_pkg::gpx_bus_resp: begin
               bus_state_ff <= gpx_pkg::gpx_bus_idle;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_irq_sets_pend: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      |event_hit |=> pend_ff) else $error("qualified event did not set request");
   chk_irq_masked: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      ext_irq_req |-> $past(pend_ff) && !$past(cpu_irq_masked)) else $error("request while masked");
   chk_fetch_clear: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      vector_fetch && !(|event_hit) |=> !pend_ff) else $error("fetch did not clear request");
   chk_sens_clear: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      wr_sens && !(|event_hit) |=> !pend_ff) else $error("sensitivity write did not clear");
   chk_no_irq_out: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      (irq_enable == 8'h00) |-> event_hit == 8'h00) else $error("event from non-interrupt pin");
   chk_push_pull: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      dir_ff[0] && opt_ff[0] && !af.af_out_en[0] |=> !pad.oe_n[0] && pad.out[0] == $past(pin_data_latch_ff[0]))
      else $error("push-pull pin not driven");
   chk_af_force: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      af.af_out_en[4] && !af.af_od[4] |=> !pad.oe_n[4] && pad.out[4] == $past(af.af_out[4]))
      else $error("peripheral output not forced");
   chk_input_float: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      !dir_ff[2] && !af.af_out_en[2] |=> pad.oe_n[2]) else $error("input pin driven");
   chk_bus_answer: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      acc |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
   // ----------------------------------------------------------------
   // further checks
   // ----------------------------------------------------------------
   // latch holds until a clear
   chk_pend_hold: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      pend_ff && !vector_fetch && !wr_sens |=> pend_ff) else $error("request lost");
   // unmasked latch reaches the cpu
   chk_req_follow: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      pend_ff && !cpu_irq_masked |=> ext_irq_req) else $error("request not raised");
   // wait mode is left on a request
   chk_wake_wait: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      pend_ff && !cpu_irq_masked && cpu_wait_mode |=> wake_req) else $error("no wake in wait");
   // halt mode is left on a request
   chk_wake_halt: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      pend_ff && !cpu_irq_masked && cpu_halt_mode |=> wake_req) else $error("no wake in halt");
   // open drain never drives high
   chk_open_drain: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      dir_ff[0] && !opt_ff[0] && !af.af_out_en[0] |=> pad.oe_n[0] || !pad.out[0])
      else $error("open drain drove high");
   // input option selects pull-up
   chk_input_pull: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      !dir_ff[3] && !af.af_out_en[3] |=> pad.pull_up[3] == $past(opt_ff[3]))
      else $error("pull-up not on option");
   // output pin gives peripheral the latch
   chk_af_latch: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      dir_ff[0] && !af.af_out_en[0] && af.af_in_en[0] |=> af_in[0] == $past(pin_data_latch_ff[0]))
      else $error("peripheral not fed latch");
   // data write lands in the latch
   chk_data_write: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      wr_data |=> pin_data_latch_ff == $past(avs_writedata[7:0])) else $error("data write lost");
   // upper read bits stay zero
   chk_read_upper: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
   // sensitivity write lands
   chk_sens_write: assert property (@(posedge clock) disable iff (!rst_sync_ff)
      wr_sens |=> ext_irq_sensitivity_ctrl_ff == $past(avs_writedata[1:0])) else $error("code not stored");
endmodule // gpx_port
`default_nettype wire

// ===== rtl/gpx_cfg.svh
// constants for the general-purpose port block: offsets, reset values, field codes
// assumes inclusion by the design files of this block that use its macros
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH
// ----------------------------------------------------------------
// register word offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define GPX_OFS_DATA 8'h00
`define GPX_OFS_DIR 8'h04
`define GPX_OFS_OPT 8'h08
`define GPX_OFS_SENS 8'h0C
`define GPX_OFS_AF_EN 8'h10
`define GPX_OFS_STATUS 8'h14
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPX_RST_PORT 8'h00
`define GPX_RST_SENS 2'h0
// ----------------------------------------------------------------
// sensitivity codes and status field positions
// ----------------------------------------------------------------
`define GPX_SENS_FALL_LOW 2'h0
`define GPX_SENS_RISE 2'h1
`define GPX_SENS_FALL 2'h2
`define GPX_SENS_BOTH 2'h3
`define GPX_ST_PEND 0
`define GPX_ST_WAKE 1
`endif

// ===== rtl/gpx_pkg.sv
// types shared by the port block
// assumes the constants header is compiled alongside
`default_nettype none
package gpx_pkg;
   // one pin group seen from the peripheral side
   typedef struct packed {
      logic [7:0] af_out_en; // peripheral drives pin
      logic [7:0] af_out; // peripheral output value
      logic [7:0] af_od; // peripheral wants open drain
      logic [7:0] af_in_en; // peripheral samples pin
   } gpx_af_type;
   // pad drive bundle
   typedef struct packed {
      logic [7:0] out; // value toward pad
      logic [7:0] oe_n; // low while driven
      logic [7:0] pull_up; // pull-up enable
   } gpx_pad_type;
   typedef enum logic [1:0] {gpx_bus_idle, gpx_bus_resp} gpx_bus_state_type;
endpackage
`default_nettype wire

// ===== rtl/gpx_edge_qual.sv
// per-pin sensitivity qualifier for external interrupt events
// assumes pin levels already synchronous to clock
`default_nettype none
`include "gpx_cfg.svh"
module gpx_edge_qual #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_sync_n,
   // pin levels and control
   input wire logic [WIDTH-1:0] pin_level,
   input wire logic [WIDTH-1:0] irq_enable,
   input wire logic [1:0] sens,
   // qualified events
   output logic [WIDTH-1:0] event_hit
);
   initial begin
      if (WIDTH < 1 || WIDTH > 8) $error("gpx_edge_qual width out of range");
   end
   logic [WIDTH-1:0] prev_ff; // last sampled level
   // previous level tracker
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prev_ff <= '1;
      end else begin
         prev_ff <= pin_level;
      end
   end
   // qualify each pin on its own, before any merging
   always_comb begin
      event_hit = '0;
      unique case (sens)
         `GPX_SENS_FALL_LOW: event_hit = ~pin_level; // low level
         `GPX_SENS_RISE: event_hit = pin_level & ~prev_ff;
         `GPX_SENS_FALL: event_hit = ~pin_level & prev_ff;
         `GPX_SENS_BOTH: event_hit = pin_level ^ prev_ff;
      endcase
      event_hit = event_hit & irq_enable;
   end
endmodule // gpx_edge_qual
`default_nettype wire

// ===== rtl/gpx_pad_mux.sv
// per-pin drive and readback selection with alternate function override
// assumes pad resolution is done outside from out and oe_n
`default_nettype none
module gpx_pad_mux #(
   parameter int WIDTH = 8
) (
   // port programming
   input wire logic [WIDTH-1:0] latch,
   input wire logic [WIDTH-1:0] dir,
   input wire logic [WIDTH-1:0] opt,
   // peripheral side
   input wire logic [WIDTH-1:0] af_out_en,
   input wire logic [WIDTH-1:0] af_out,
   input wire logic [WIDTH-1:0] af_od,
   input wire logic [WIDTH-1:0] af_in_en,
   input wire logic [WIDTH-1:0] pin_level,
   // results
   output logic [WIDTH-1:0] nxt_out,
   output logic [WIDTH-1:0] nxt_oe_n,
   output logic [WIDTH-1:0] nxt_pull,
   output logic [WIDTH-1:0] nxt_af_in,
   output logic [WIDTH-1:0] read_val
);
   initial begin
      if (WIDTH < 1 || WIDTH > 8) $error("gpx_pad_mux width out of range");
   end
   // one pin at a time, alternate function first
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (af_out_en[i]) begin
            // peripheral forces output, its own drive style
            nxt_out[i] = af_out[i];
            nxt_oe_n[i] = af_od[i] & af_out[i];
            nxt_pull[i] = 1'b0;
         end else if (dir[i]) begin
            // opt=1 push-pull, opt=0 open drain floats on one
            nxt_out[i] = latch[i];
            nxt_oe_n[i] = ~opt[i] & latch[i];
            nxt_pull[i] = 1'b0;
         end else begin
            // input: latch never reaches the pad
            nxt_out[i] = 1'b0;
            nxt_oe_n[i] = 1'b1;
            nxt_pull[i] = opt[i];
         end
         // output pin feeds peripheral from latch
         nxt_af_in[i] = (dir[i] && !af_out_en[i]) ? latch[i] : pin_level[i];
         if (!af_in_en[i]) nxt_af_in[i] = 1'b0;
         // readback: latch in output without af, pin in output under af, af value or pin in input
         if (dir[i] && !af_out_en[i]) read_val[i] = latch[i];
         else if (!dir[i] && af_out_en[i]) read_val[i] = af_out[i];
         else read_val[i] = pin_level[i];
      end
   end
endmodule // gpx_pad_mux
`default_nettype wire

// ===== bench/gpx_pin_model.sv
// board side of the port: resolves pad drive, pull-up and an external source
// assumes the pad bundle of the port and a bench-driven external source
`default_nettype none
module gpx_pin_model (
   // clock
   input wire logic clock,
   // port drive
   input wire gpx_pkg::gpx_pad_type pad,
   // external source
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   // resolved levels
   output logic [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] float_ff = 8'h55; // wobble for undriven pins
   // a floating pin changes every cycle, so no stale level can pass for a real one
   always_ff @(posedge clock) begin
      float_ff <= ~float_ff;
   end
   // port drive first, then the outside source, then pull-up, else floating
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pad.oe_n[i]) begin
            pin_in[i] = pad.out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pad.pull_up[i]) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = float_ff[i]; // floating input or released open drain
         end
      end
   end
endmodule // gpx_pin_model
`default_nettype wire

// ===== bench/test_gpx_port.sv
// self-checking bench of the port: bus, pads, alternate functions, interrupts
// assumes the port design, its header and the pin model
`default_nettype none
`include "gpx_cfg.svh"
module test_gpx_port;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic cpu_irq_masked = 1'b0, vector_fetch = 1'b0, cpu_wait_mode = 1'b0, cpu_halt_mode = 1'b0;
   logic ext_irq_req, wake_req;
   gpx_pkg::gpx_af_type af = '0;
   gpx_pkg::gpx_pad_type pad;
   logic [7:0] af_in, pin_in, v, w;
   logic [7:0] ext_en = 8'hff, ext_val = 8'h00;
   logic [33:0] exp_q[$]; // expected {response, readdata}
   int mismatches = 0, n_checks = 0, cycles = 0;
   // ----------------------------------------------------------------
   // design and board
   // ----------------------------------------------------------------
   gpx_port dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .cpu_irq_masked(cpu_irq_masked), .vector_fetch(vector_fetch), .cpu_wait_mode(cpu_wait_mode),
      .cpu_halt_mode(cpu_halt_mode), .ext_irq_req(ext_irq_req), .wake_req(wake_req), .af(af),
      .af_in(af_in), .pin_in(pin_in), .pad(pad));
   gpx_pin_model pins (.clock(clock), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   initial begin
      forever #5 clock = ~clock;
   end
   // ----------------------------------------------------------------
   // compare and bus tasks
   // ----------------------------------------------------------------
   task automatic fail(string msg);
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
   endtask
   task automatic chk8(logic [7:0] got, logic [7:0] exp, string what);
      n_checks++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
   endtask
   task automatic chkf(logic got, logic exp, string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask
   task automatic chk_rd(logic [33:0] e);
      n_checks++;
      if ({avs_response, avs_readdata} !== e) fail($sformatf("read got %h exp %h", avs_readdata, e));
   endtask
   // holds the request until waitrequest is sampled low
   task automatic bus(logic wr, logic [7:0] a, logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) fail("bus stall");
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e, logic [1:0] r = 2'b00);
      exp_q.push_back({r, 24'h00_0000, e});
      bus(1'b0, a, 8'h00);
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge clock);
   endtask
   task automatic fetch();
      vector_fetch <= 1'b1;
      @(posedge clock);
      vector_fetch <= 1'b0;
      tick(3);
   endtask
   // read data watcher takes the oldest note
   always @(posedge clock) begin
      if (avs_read && !avs_waitrequest) begin
         if (exp_q.size() == 0) fail("unexpected read");
         else chk_rd(exp_q.pop_front());
      end
   end
   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail("timeout");
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0 && exp_q.size() == 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      v = 8'($urandom(32'h0000_f292));
      ext_val <= 8'($urandom);
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      tick(4);
      rd(`GPX_OFS_DIR, 8'h00); // direction reset
      rd(`GPX_OFS_OPT, 8'h00); // option reset
      rd(`GPX_OFS_DATA, ext_val); // input reads pins
      chk8(pad.oe_n, 8'hff, "oe_n"); // all inputs
      chk8(pad.pull_up, 8'h00, "pull"); // floating
      $display("test reset done");
      // input mode: latch write and peripheral input
      v = 8'($urandom);
      af.af_in_en <= 8'hff;
      bus(1'b1, `GPX_OFS_DATA, v); // whole byte written
      tick(3);
      chk8(pad.oe_n, 8'hff, "oe_n in"); // pins untouched
      chk8(af_in, ext_val, "af_in"); // peripheral sees pins
      rd(`GPX_OFS_DATA, ext_val); // pins still readable
      $display("test input done");
      // push-pull then open drain output
      ext_en <= 8'h00;
      af.af_in_en <= 8'h00;
      bus(1'b1, `GPX_OFS_OPT, 8'hff);
      bus(1'b1, `GPX_OFS_DIR, 8'hff);
      tick(3);
      chk8(pad.oe_n, 8'h00, "oe_n pp"); // driven
      chk8(pad.out, v, "out pp"); // bit n to pin n
      rd(`GPX_OFS_DATA, v); // latch read back
      bus(1'b1, `GPX_OFS_OPT, 8'h00);
      tick(3);
      chk8(pad.oe_n, v, "oe_n od"); // ones float
      chk8(pad.out | pad.oe_n, v, "out od"); // zeros drive low
      rd(8'h40, 8'h00, 2'b10); // unmapped address refused
      $display("test output done");
      // alternate functions: pins 7:4 peripheral out on inputs, 3:0 peripheral in on outputs
      bus(1'b1, `GPX_OFS_DIR, 8'h0f);
      bus(1'b1, `GPX_OFS_OPT, 8'h0f); // no interrupt inputs under af
      for (int od = 0; od < 2; od++) begin
         w = 8'($urandom);
         af <= '{af_out_en: 8'hf0, af_out: w, af_od: od ? 8'hf0 : 8'h00, af_in_en: 8'h0f};
         tick(3);
         chk8(pad.oe_n, od ? {w[7:4], 4'h0} : 8'h00, "oe_n af"); // forced output
         chk8(pad.out | pad.oe_n, {w[7:4], v[3:0]}, "out af"); // af overrides
         chk8(af_in, {4'h0, v[3:0]}, "af_in out"); // latch to peripheral
         rd(`GPX_OFS_DATA, {w[7:4], v[3:0]}); // af output read back
         rd(`GPX_OFS_AF_EN, 8'hf0); // af enables visible
      end
      af <= '0;
      $display("test alternate done");
      // interrupts: pin 0 pull-up interrupt input, every sensitivity code
      ext_en <= 8'hff;
      ext_val <= 8'hff;
      bus(1'b1, `GPX_OFS_DIR, 8'h00);
      bus(1'b1, `GPX_OFS_OPT, 8'h01);
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, `GPX_OFS_SENS, s[7:0]);
         tick(3);
         chkf(ext_irq_req, 1'b0, "irq clr"); // sensitivity write clears
         ext_val <= 8'hfe;
         tick(3);
         chkf(ext_irq_req, s != 1, "irq fall"); // qualified by code
         fetch();
         chkf(ext_irq_req, s == 0, "irq fetch"); // fetch clears, low level repends
         ext_val <= 8'hff;
         tick(3);
         chkf(ext_irq_req, s != 2, "irq rise"); // qualified by code
         fetch();
         chkf(ext_irq_req, 1'b0, "irq fetch2"); // fetch clears
      end
      $display("test sensitivity done");
      // mask, wake, or of pins
      bus(1'b1, `GPX_OFS_OPT, 8'h03);
      cpu_irq_masked <= 1'b1;
      ext_val <= 8'hfd;
      tick(3);
      chkf(ext_irq_req, 1'b0, "irq masked"); // mask blocks
      cpu_irq_masked <= 1'b0;
      cpu_wait_mode <= 1'b1;
      tick(3);
      chkf(ext_irq_req, 1'b1, "irq pin1"); // pins ored, pend kept
      chkf(wake_req, 1'b1, "wake wait"); // leaves wait
      cpu_wait_mode <= 1'b0;
      cpu_halt_mode <= 1'b1;
      tick(3);
      chkf(wake_req, 1'b1, "wake halt"); // leaves halt
      chk8(pad.pull_up, 8'h03, "pull halt"); // port kept, pull-up on option
      rd(`GPX_OFS_STATUS, 8'h03); // request and wake in status
      bus(1'b1, `GPX_OFS_SENS, 8'h03);
      tick(3);
      chkf(ext_irq_req, 1'b0, "irq sens"); // same value still clears
      chkf(wake_req, 1'b0, "wake off"); // no pending, no wake
      rd(`GPX_OFS_SENS, 8'h03); // code read back
      cpu_halt_mode <= 1'b0;
      bus(1'b1, `GPX_OFS_OPT, 8'h00);
      ext_val <= 8'hff;
      tick(2);
      ext_val <= 8'h00;
      tick(3);
      chkf(ext_irq_req, 1'b0, "irq plain"); // floating input gives none
      $display("test interrupt done");
      tick(2);
      final_report();
   end
endmodule // test_gpx_port
`default_nettype wire
